// ### rtl/psf_pkg.sv
// Constants and carrier types for the port-select / status / frequency-counter register slice
//
// Contract
// - Self-test CRC errors counted, saturating at 255
// - New self-test or clear bit zeroes counter
// - Secondary pick reads second port error count
// - Pin status low reflects sampled pin levels
// - Secondary pick shows second link pin levels
// - Pin status high bit 0 shows pin 8
// - Second address enable answers device address plus one
// - Second address reaches second port and shared
// - Secondary pick: write/read second port and shared
// - Primary pick: write/read first port and shared
// - Both picks set: reads return second port
// - Secondary pick steers pin controls to remote
// - Second address enable overrides both pick bits
// - Counter write starts interval of value times 40ns
// - Counter read returns last completed interval count
// - Frequency count saturates at 0xFF, no wrap
package psf_pkg;

    // Register offsets
    localparam logic [7:0] OFS_BC_ERR   = 8'h1B;
    localparam logic [7:0] OFS_PIN_LO   = 8'h1C;
    localparam logic [7:0] OFS_PIN_HI   = 8'h1D;
    localparam logic [7:0] OFS_PORT_SEL = 8'h1E;
    localparam logic [7:0] OFS_FREQ     = 8'h1F;

    // Port select field positions
    localparam int SEL_P0_BIT    = 0;
    localparam int SEL_P1_BIT    = 1;
    localparam int SEL_ADDR2_BIT = 2;
    localparam int SEL_WIDTH     = 3;

    // Reset values
    localparam logic [2:0] PORT_SEL_RST = 3'h1;
    localparam logic [7:0] BC_ERR_RST   = 8'h00;
    localparam logic [7:0] FREQ_RST     = 8'h00;

    // Saturation ceiling and second address step
    localparam logic [7:0] CNT_MAX   = 8'hFF;
    localparam logic [6:0] ADDR2_INC = 7'h01;

    // Interval timing: one oscillator period in system clocks
    localparam int         OSC_PERIOD_NS = 40;
    localparam int         CLK_PERIOD_NS = 5;
    localparam int         OSC_CYC_INT   = OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [3:0] OSC_CYC       = 4'(OSC_CYC_INT);

    // Register access request from the two-wire slave engine
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [6:0] slave;
        logic [7:0] offset;
        logic [7:0] wdata;
    } psf_req_s;

    // Answer to a request
    typedef struct packed {
        logic       hit;
        logic       own;
        logic [7:0] rdata;
    } psf_rsp_s;

    // Steering of the access to per-port and shared register banks
    typedef struct packed {
        logic wr_port0;
        logic wr_port1;
        logic wr_shared;
        logic rd_port1;
    } psf_route_s;

    typedef enum logic [1:0] {
        FQ_IDLE = 2'b01,
        FQ_RUN  = 2'b10
    } psf_freq_e;

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == CNT_MAX) ? v : 8'(v + 8'h01);
    endfunction

endpackage

// ### rtl/psf_freq_meter.sv
// Pixel clock edge counter over a timed oscillator interval
`timescale 1ns/100ps
module psf_freq_meter (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    // Control
    input  wire logic       start_i,
    input  wire logic [7:0] interval_i,
    // Measured clock pin
    input  wire logic       pix_clk_i,
    // Result and busy
    output logic [7:0]      result_o,
    output logic            busy_o
);

    logic             pix_s1_q, pix_s2_q, pix_s3_q;
    psf_pkg::psf_freq_e state_q, state_d;
    logic [3:0]       sub_q, sub_d;
    logic [7:0]       ticks_q, ticks_d;
    logic [7:0]       cnt_q, cnt_d;
    logic [7:0]       result_q, result_d;
    logic             edge_seen;

    // Edge taken after the second stage only
    assign edge_seen = pix_s2_q & ~pix_s3_q;

    always_comb begin
        state_d  = state_q;
        sub_d    = sub_q;
        ticks_d  = ticks_q;
        cnt_d    = cnt_q;
        result_d = result_q;
        case (state_q)
            psf_pkg::FQ_RUN: begin
                if (edge_seen) begin
                    cnt_d = psf_pkg::sat_inc(cnt_q);
                end
                if (sub_q == 4'(psf_pkg::OSC_CYC - 4'h1)) begin
                    sub_d   = 4'h0;
                    ticks_d = 8'(ticks_q - 8'h01);
                    if (ticks_q == 8'h01) begin
                        state_d  = psf_pkg::FQ_IDLE;
                        result_d = edge_seen ? psf_pkg::sat_inc(cnt_q) : cnt_q;
                    end
                end else begin
                    sub_d = 4'(sub_q + 4'h1);
                end
            end
            default: begin
                state_d = psf_pkg::FQ_IDLE;
            end
        endcase
        // A new write restarts, even mid-interval
        if (start_i) begin
            sub_d   = 4'h0;
            ticks_d = interval_i;
            cnt_d   = 8'h00;
            if (interval_i == 8'h00) begin
                state_d  = psf_pkg::FQ_IDLE;
                result_d = 8'h00;
            end else begin
                state_d = psf_pkg::FQ_RUN;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pix_s1_q <= 1'b0;
            pix_s2_q <= 1'b0;
            pix_s3_q <= 1'b0;
            state_q  <= psf_pkg::FQ_IDLE;
            sub_q    <= 4'h0;
            ticks_q  <= 8'h00;
            cnt_q    <= 8'h00;
            result_q <= psf_pkg::FREQ_RST;
        end else begin
            pix_s1_q <= pix_clk_i;
            pix_s2_q <= pix_s1_q;
            pix_s3_q <= pix_s2_q;
            state_q  <= state_d;
            sub_q    <= sub_d;
            ticks_q  <= ticks_d;
            cnt_q    <= cnt_d;
            result_q <= result_d;
        end
    end

    // Sampled, so pixel clocks above half of clk_sys alias low
    assign result_o = result_q;
    assign busy_o   = (state_q == psf_pkg::FQ_RUN);

endmodule

// ### rtl/psf_port_status_regs.sv
// Register slice: self-test error count, pin status, port select, frequency counter
`timescale 1ns/100ps
module psf_port_status_regs (
    // Clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  rstn_i,
    // Register access from the two-wire slave engine
    input  wire psf_pkg::psf_req_s     req_i,
    input  wire logic [6:0]            dev_id_i,
    output psf_pkg::psf_rsp_s          rsp_o,
    output psf_pkg::psf_route_s        route_o,
    // Self-test back channel
    input  wire logic                  built_in_self_test_active_i,
    input  wire logic                  built_in_self_test_start_i,
    input  wire logic                  bc_err_clear_i,
    input  wire logic [1:0]            bc_crc_err_i,
    // Pin levels
    input  wire logic [3:0]            gpio_pin_i,
    input  wire logic [3:0]            reg_pin_i,
    input  wire logic [3:0]            remote_pin_i,
    input  wire logic                  pix_clk_i,
    // Port steering and frequency counter busy
    output logic                       addr2_en_o,
    output logic                       gpio_remote_ctrl_o,
    output logic                       freq_busy_o
);

    // Pin synchronisers
    logic [3:0]            gpio_s1_q, gpio_s2_q;
    logic [3:0]            reg_s1_q, reg_s2_q;

    // Register state
    logic [2:0]            sel_q, sel_d;
    logic [7:0]            err0_q, err0_d;
    logic [7:0]            err1_q, err1_d;
    psf_pkg::psf_rsp_s     rsp_q, rsp_d;
    psf_pkg::psf_route_s   route_q, route_d;
    logic                  remote_q, remote_d;

    // Decode
    logic                  hit_pri;
    logic                  hit_sec;
    logic                  hit_any;
    logic                  own;
    logic                  wr_own;
    logic                  p0_pick;
    logic                  p1_pick;
    logic                  view1;
    logic                  freq_start;
    logic [7:0]            freq_result;
    logic                  freq_busy;

    // Second address enable overrides both pick bits
    assign p0_pick = sel_q[psf_pkg::SEL_P0_BIT] & ~sel_q[psf_pkg::SEL_ADDR2_BIT];
    assign p1_pick = sel_q[psf_pkg::SEL_P1_BIT] & ~sel_q[psf_pkg::SEL_ADDR2_BIT];

    assign hit_pri = req_i.valid && (req_i.slave == dev_id_i);
    assign hit_sec = req_i.valid && sel_q[psf_pkg::SEL_ADDR2_BIT] && !hit_pri
                     && (req_i.slave == 7'(dev_id_i + psf_pkg::ADDR2_INC));
    assign hit_any = hit_pri | hit_sec;

    assign own = (req_i.offset >= psf_pkg::OFS_BC_ERR) && (req_i.offset <= psf_pkg::OFS_FREQ);
    assign wr_own = hit_any & req_i.write & own;

    // Second port view: second address, or secondary pick on primary
    assign view1 = hit_sec | (hit_pri & p1_pick);

    assign freq_start = wr_own && (req_i.offset == psf_pkg::OFS_FREQ);

    psf_freq_meter u_freq (
        .clk_sys_i  (clk_sys_i),
        .rstn_i     (rstn_i),
        .start_i    (freq_start),
        .interval_i (req_i.wdata),
        .pix_clk_i  (pix_clk_i),
        .result_o   (freq_result),
        .busy_o     (freq_busy)
    );

    // Port select register
    always_comb begin
        sel_d = sel_q;
        if (wr_own && (req_i.offset == psf_pkg::OFS_PORT_SEL)) begin
            sel_d = req_i.wdata[psf_pkg::SEL_WIDTH-1:0];
        end
    end

    // Self-test error counters; start or clear in the same cycle as an error keeps that error
    always_comb begin
        err0_d = err0_q;
        err1_d = err1_q;
        if (built_in_self_test_start_i || bc_err_clear_i) begin
            err0_d = 8'h00;
            err1_d = 8'h00;
        end
        if (built_in_self_test_active_i && bc_crc_err_i[0]) begin
            err0_d = psf_pkg::sat_inc(err0_d);
        end
        if (built_in_self_test_active_i && bc_crc_err_i[1]) begin
            err1_d = psf_pkg::sat_inc(err1_d);
        end
    end

    // Bank steering of the access
    always_comb begin
        route_d = '0;
        if (hit_sec) begin
            route_d.wr_port1  = req_i.write;
            route_d.wr_shared = req_i.write;
            route_d.rd_port1  = ~req_i.write;
        end else if (hit_pri) begin
            route_d.wr_shared = req_i.write;
            if (sel_q[psf_pkg::SEL_ADDR2_BIT]) begin
                route_d.wr_port0 = req_i.write;
            end else begin
                route_d.wr_port0 = req_i.write & p0_pick;
                route_d.wr_port1 = req_i.write & p1_pick;
            end
            route_d.rd_port1 = ~req_i.write & p1_pick;
        end
    end

    // Pin controls 3..0 drive the second link while secondary pick holds
    always_comb begin
        remote_d = p1_pick;
    end

    // Read data
    always_comb begin
        rsp_d       = '0;
        rsp_d.hit   = hit_any;
        rsp_d.own   = hit_any & own;
        if (hit_any && !req_i.write) begin
            if (req_i.offset == psf_pkg::OFS_BC_ERR) begin
                rsp_d.rdata = view1 ? err1_q : err0_q;
            end else if (req_i.offset == psf_pkg::OFS_PIN_LO) begin
                rsp_d.rdata[7:5] = reg_s2_q[2:0];
                rsp_d.rdata[4]   = 1'b0;
                rsp_d.rdata[3:0] = view1 ? remote_pin_i : gpio_s2_q;
            end else if (req_i.offset == psf_pkg::OFS_PIN_HI) begin
                rsp_d.rdata = {7'h00, reg_s2_q[3]};
            end else if (req_i.offset == psf_pkg::OFS_PORT_SEL) begin
                rsp_d.rdata = {5'h00, sel_q};
            end else if (req_i.offset == psf_pkg::OFS_FREQ) begin
                rsp_d.rdata = freq_result;
            end else begin
                rsp_d.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gpio_s1_q <= 4'h0;
            gpio_s2_q <= 4'h0;
            reg_s1_q  <= 4'h0;
            reg_s2_q  <= 4'h0;
            sel_q     <= psf_pkg::PORT_SEL_RST;
            err0_q    <= psf_pkg::BC_ERR_RST;
            err1_q    <= psf_pkg::BC_ERR_RST;
            rsp_q     <= '0;
            route_q   <= '0;
            remote_q  <= 1'b0;
        end else begin
            gpio_s1_q <= gpio_pin_i;
            gpio_s2_q <= gpio_s1_q;
            reg_s1_q  <= reg_pin_i;
            reg_s2_q  <= reg_s1_q;
            sel_q     <= sel_d;
            err0_q    <= err0_d;
            err1_q    <= err1_d;
            rsp_q     <= rsp_d;
            route_q   <= route_d;
            remote_q  <= remote_d;
        end
    end

    // Busy is registered once more so every output leaves a flop of this module
    logic freq_busy_q;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            freq_busy_q <= 1'b0;
        end else begin
            freq_busy_q <= freq_busy;
        end
    end

    assign rsp_o              = rsp_q;
    assign route_o            = route_q;
    assign addr2_en_o         = sel_q[psf_pkg::SEL_ADDR2_BIT];
    assign gpio_remote_ctrl_o = remote_q;
    assign freq_busy_o        = freq_busy_q;

endmodule

// ### verification/psf_chk.sv
// Assertion checker for the port-select register slice
`timescale 1ns/100ps
module psf_chk (
    // Clock and reset
    input wire logic                clk_sys_i,
    input wire logic                rstn_i,
    // Register bus
    input wire psf_pkg::psf_req_s   req_i,
    input wire logic [6:0]          dev_id_i,
    input wire psf_pkg::psf_rsp_s   rsp_o,
    input wire psf_pkg::psf_route_s route_o,
    // Steering and frequency counter busy
    input wire logic                addr2_en_o,
    input wire logic                gpio_remote_ctrl_o,
    input wire logic                freq_busy_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    logic       p1;
    logic       p2;
    logic       rd;
    logic [7:0] rmask;
    assign p1 = req_i.valid && req_i.slave == dev_id_i;
    assign p2 = req_i.valid && req_i.slave == 7'(dev_id_i + 7'h01) && !p1;
    assign rd = !req_i.write;
    // Reserved bits per offset
    assign rmask = (req_i.offset == 8'h1C) ? 8'h10 : (req_i.offset == 8'h1D) ? 8'hFE :
                   (req_i.offset == 8'h1E) ? 8'hF8 : 8'h00;
    chk_primary_hit: assert property (p1 && req_i.offset >= 8'h1B && req_i.offset <= 8'h1F |=> rsp_o.hit && rsp_o.own)
        else $error("primary access not answered");
    chk_second_hit: assert property (p2 && addr2_en_o |=> rsp_o.hit)
        else $error("second address not answered");
    chk_second_off: assert property (p2 && !addr2_en_o |=> !rsp_o.hit && !rsp_o.own)
        else $error("second address answered while disabled");
    chk_second_read: assert property (p2 && addr2_en_o && rd |=> route_o.rd_port1)
        else $error("second address read not sent to port 1");
    chk_second_write: assert property (p2 && addr2_en_o && !rd |=> route_o.wr_port1 && route_o.wr_shared && !route_o.wr_port0)
        else $error("second address write misrouted");
    chk_pick_write: assert property (p1 && gpio_remote_ctrl_o && !$past(req_i.valid) && !rd |=> route_o.wr_port1 && route_o.wr_shared)
        else $error("secondary pick write misrouted");
    chk_reserved_zero: assert property (p1 && rd |=> (rsp_o.rdata & $past(rmask)) == 8'h00)
        else $error("reserved bits read nonzero");
    chk_addr2_override: assert property (addr2_en_o && $past(addr2_en_o) |-> !gpio_remote_ctrl_o)
        else $error("pin steering active with second address");
    chk_freq_window: assert property (p1 && !rd && req_i.offset == 8'h1F && req_i.wdata == 8'h01 && !freq_busy_o
        |-> ##[1:4] $rose(freq_busy_o) ##7 freq_busy_o ##[1:3] !freq_busy_o)
        else $error("one-period interval not eight cycles");
    cover property (p2 && addr2_en_o);
    cover property ($rose(freq_busy_o));
    cover property (p1 && gpio_remote_ctrl_o);
endmodule
bind psf_port_status_regs psf_chk u_chk (
    .clk_sys_i          (clk_sys_i),
    .rstn_i             (rstn_i),
    .req_i              (req_i),
    .dev_id_i           (dev_id_i),
    .rsp_o              (rsp_o),
    .route_o            (route_o),
    .addr2_en_o         (addr2_en_o),
    .gpio_remote_ctrl_o (gpio_remote_ctrl_o),
    .freq_busy_o        (freq_busy_o)
);

// ### verification/psf_host_model.sv
// Two-wire bus host model issuing byte register accesses
`timescale 1ns/100ps
module psf_host_model (
    // Clock
    input  wire logic              clk_sys_i,
    // Register bus
    output psf_pkg::psf_req_s      req_o,
    input  wire psf_pkg::psf_rsp_s rsp_i
);
    initial req_o = '0;
    // Idle fields are inverted so stale values never pass as a request
    task automatic xfer(input logic w, input logic [6:0] sl, input logic [7:0] ofs, input logic [7:0] wd,
                        output psf_pkg::psf_rsp_s r);
        @(posedge clk_sys_i);
        req_o <= '{valid: 1'b1, write: w, slave: sl, offset: ofs, wdata: wd};
        @(posedge clk_sys_i);
        req_o <= '{valid: 1'b0, write: ~w, slave: ~sl, offset: ~ofs, wdata: ~wd};
        @(posedge clk_sys_i);
        r = rsp_i;
    endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the port-select register slice
`timescale 1ns/100ps
module tb_top;
    localparam logic [6:0] DEV = 7'h3A;
    localparam logic [6:0] DEV2 = 7'h3B;
    logic                clk_sys_i, rstn_i, pix_en, pix_clk, built_in_self_test_active, built_in_self_test_start, err_clear;
    logic                addr2_en, remote_ctrl, freq_busy;
    logic [1:0]          crc_err;
    logic [3:0]          gpio_pin, reg_pin, remote_pin;
    psf_pkg::psf_req_s   req;
    psf_pkg::psf_rsp_s   rsp, r;
    psf_pkg::psf_route_s route;
    int                  errors, num_checks, cycles;
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // Pixel clock stands low while gated off
    initial begin
        pix_clk = 1'b0;
        forever #11 pix_clk = pix_en & ~pix_clk;
    end
    psf_port_status_regs DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req), .dev_id_i(DEV),
        .rsp_o(rsp), .route_o(route), .built_in_self_test_active_i(built_in_self_test_active), .built_in_self_test_start_i(built_in_self_test_start),
        .bc_err_clear_i(err_clear), .bc_crc_err_i(crc_err), .gpio_pin_i(gpio_pin), .reg_pin_i(reg_pin),
        .remote_pin_i(remote_pin), .pix_clk_i(pix_clk), .addr2_en_o(addr2_en),
        .gpio_remote_ctrl_o(remote_ctrl), .freq_busy_o(freq_busy));
    psf_host_model HOST (.clk_sys_i(clk_sys_i), .req_o(req), .rsp_i(rsp));
    task automatic test_done();
        $display("errors=%0d checks=%0d", errors, num_checks);
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            test_done();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [6:0] sl, input logic [7:0] ofs, input logic [7:0] exp);
        HOST.xfer(1'b0, sl, ofs, 8'h00, r);
        check(r.rdata, exp);
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] wd);
        HOST.xfer(1'b1, DEV, ofs, wd, r);
    endtask
    task automatic errs(input logic [1:0] m, input int n);
        repeat (n) begin
            @(posedge clk_sys_i) crc_err <= m;
            @(posedge clk_sys_i) crc_err <= 2'b00;
        end
    endtask
    task automatic t_regs();
        rdchk(DEV, 8'h1E, 8'h01);
        rdchk(DEV, 8'h1F, 8'h00);
        wr(8'h1E, 8'hFF);
        rdchk(DEV, 8'h1E, 8'h07);
        wr(8'h1B, 8'h55);
        rdchk(DEV, 8'h1B, 8'h00);
    endtask
    task automatic t_pins();
        wr(8'h1E, 8'h01);
        repeat (4) @(posedge clk_sys_i);
        rdchk(DEV, 8'h1C, 8'h6A);
        rdchk(DEV, 8'h1D, 8'h01);
        wr(8'h1E, 8'h02);
        rdchk(DEV, 8'h1C, 8'h65);
        check({7'h00, remote_ctrl}, 8'h01);
    endtask
    task automatic t_errors();
        wr(8'h1E, 8'h01);
        built_in_self_test_active <= 1'b1;
        errs(2'b01, 300);
        rdchk(DEV, 8'h1B, 8'hFF);
        @(posedge clk_sys_i) err_clear <= 1'b1;
        @(posedge clk_sys_i) err_clear <= 1'b0;
        rdchk(DEV, 8'h1B, 8'h00);
        errs(2'b01, 2);
        errs(2'b10, 3);
        built_in_self_test_active <= 1'b0;
        errs(2'b11, 4);
        rdchk(DEV, 8'h1B, 8'h02);
        wr(8'h1E, 8'h02);
        wr(8'h1E, 8'h03);
        rdchk(DEV, 8'h1B, 8'h03);
        wr(8'h1E, 8'h02);
        rdchk(DEV, 8'h1B, 8'h03);
        // Second address only after its enable is set
        wr(8'h1E, 8'h06);
        rdchk(DEV, 8'h1B, 8'h02);
        rdchk(DEV2, 8'h1B, 8'h03);
        check({7'h00, remote_ctrl}, 8'h00);
        check({7'h00, addr2_en}, 8'h01);
        HOST.xfer(1'b1, DEV2, 8'h20, 8'h5A, r);
        wr(8'h1E, 8'h01);
        HOST.xfer(1'b0, DEV2, 8'h1B, 8'h00, r);
        check({7'h00, r.hit}, 8'h00);
        @(posedge clk_sys_i) built_in_self_test_start <= 1'b1;
        @(posedge clk_sys_i) built_in_self_test_start <= 1'b0;
        rdchk(DEV, 8'h1B, 8'h00);
    endtask
    task automatic wait_idle();
        repeat (4) @(posedge clk_sys_i);
        for (int i = 0; i < 3000 && freq_busy !== 1'b0; i++)
            @(posedge clk_sys_i);
    endtask
    task automatic t_freq();
        wr(8'h1F, 8'h01);
        wait_idle();
        rdchk(DEV, 8'h1F, 8'h00);
        pix_en <= 1'b1;
        wr(8'h1F, 8'hFF);
        rdchk(DEV, 8'h1F, 8'h00);
        wait_idle();
        rdchk(DEV, 8'h1F, 8'hFF);
        // Known 22 ns pixel period over 11 oscillator periods: 440 ns holds 20 rising edges
        wr(8'h1F, 8'h0B);
        wait_idle();
        rdchk(DEV, 8'h1F, 8'h14);
        wr(8'h1F, 8'h00);
        rdchk(DEV, 8'h1F, 8'h00);
        pix_en <= 1'b0;
        wr(8'h1F, 8'h02);
        wait_idle();
        rdchk(DEV, 8'h1F, 8'h00);
    endtask
    initial begin
        {rstn_i, pix_en, built_in_self_test_active, built_in_self_test_start, err_clear, crc_err} = '0;
        {gpio_pin, reg_pin, remote_pin} = {4'hA, 4'hB, 4'h5};
        {errors, num_checks, cycles} = '0;
        repeat (6) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_regs();
        t_pins();
        t_errors();
        t_freq();
        test_done();
    end
endmodule
